// ==== bench/spt_host_model.sv ====
// host-side uart character source
`timescale 1ns/1ns
`default_nettype none
module spt_host_model (
	input  wire logic       i_clk,
	output var  logic       o_valid,
	output var  logic [7:0] o_data
);
	initial begin
		o_valid <= 1'b0;
		o_data <= 8'h00;
	end
	// idle data is the inverse of the last char, so a stale byte never looks fresh
	task automatic send(input int n, input int gap, input logic [7:0] base);
		for (int k = 0; k < n; k++) begin
			o_valid <= 1'b1;
			o_data <= base + k[7:0];
			@(posedge i_clk);
			if (gap > 0) begin
				o_valid <= 1'b0;
				o_data <= ~(base + k[7:0]);
				repeat (gap) @(posedge i_clk);
			end
		end
		o_valid <= 1'b0;
		o_data <= ~(base + n[7:0] - 8'h01);
	endtask
endmodule // spt_host_model
`default_nettype wire

// ==== bench/spt_trigger_assertions.sv ====
// concurrent checks on the trigger block's ports
`timescale 1ns/1ns
`default_nettype none
`include "spt_defines.vh"
module spt_trigger_chk (
	input wire logic        I_SYS_CLK,
	input wire logic        I_SYS_RST,
	input wire logic        O_TX_VALID,
	input wire logic [7:0]  O_TX_DATA,
	input wire logic        O_TX_LAST,
	input wire logic        I_TX_READY,
	input wire logic        I_AXI_AWVALID,
	input wire logic        O_AXI_AWREADY,
	input wire logic        I_AXI_WVALID,
	input wire logic        O_AXI_WREADY,
	input wire logic        O_AXI_BVALID,
	input wire logic        I_AXI_BREADY,
	input wire logic [1:0]  O_AXI_BRESP,
	input wire logic        I_AXI_ARVALID,
	input wire logic        O_AXI_ARREADY,
	input wire logic        O_AXI_RVALID,
	input wire logic        I_AXI_RREADY,
	input wire logic [31:0] O_AXI_RDATA
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_SYS_RST);
	a_rst_quiet: assert property (
		$fell(I_SYS_RST) |-> !O_TX_VALID && !O_AXI_BVALID && !O_AXI_RVALID)
		else $error("outputs active right after reset");
	a_tx_hold: assert property (
		O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST))
		else $error("stalled rf byte changed");
	a_wr_answer: assert property (
		I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY |-> ##[1:2] O_AXI_BVALID)
		else $error("write response late");
	a_b_hold: assert property (
		O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
		else $error("write response dropped");
	a_b_clear: assert property (
		O_AXI_BVALID && I_AXI_BREADY |=> !O_AXI_BVALID)
		else $error("write response repeated");
	a_aw_block: assert property (
		O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY)
		else $error("new write taken during response");
	a_ar_gate: assert property (
		O_AXI_ARREADY == !O_AXI_RVALID)
		else $error("read address ready wrong");
	a_rd_answer: assert property (
		I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID)
		else $error("read data late");
	a_r_hold: assert property (
		O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
		else $error("read data dropped");
	c_last: cover property (O_TX_VALID && I_TX_READY && O_TX_LAST);
	c_stall: cover property (O_TX_VALID && !I_TX_READY);
	c_slverr: cover property (O_AXI_BVALID && O_AXI_BRESP == `SPT_RESP_SLVERR);
endmodule // spt_trigger_chk
`default_nettype wire

// ==== bench/spt_trigger_bench.sv ====
// self-checking bench for the packetization trigger
`timescale 1ns/1ns
`default_nettype none
`include "spt_defines.vh"
module serial_packetization_trigger_bench;
	localparam int SETUP = 20;
	localparam logic [7:0] A_TH = `SPT_IDX_THRESH << 2;
	localparam logic [7:0] A_TO = `SPT_IDX_TIMEOUT << 2;
	localparam logic [7:0] A_MP = `SPT_IDX_MAXPKT << 2;
	localparam logic [7:0] A_CF = `SPT_IDX_SERCFG << 2;
	localparam logic [7:0] A_ST = `SPT_IDX_STATUS << 2;
	logic        I_SYS_CLK = 0, I_SYS_RST = 1, I_TX_READY = 0;
	logic        I_AXI_AWVALID = 0, I_AXI_WVALID = 0, I_AXI_BREADY = 0;
	logic        I_AXI_ARVALID = 0, I_AXI_RREADY = 0;
	logic [7:0]  I_AXI_AWADDR = 0, I_AXI_ARADDR = 0, O_TX_DATA;
	logic [31:0] I_AXI_WDATA = 0, O_AXI_RDATA;
	logic [3:0]  I_AXI_WSTRB = 4'hF;
	wire         I_RX_VALID, O_RX_READY, O_TX_VALID, O_TX_LAST, O_AXI_AWREADY;
	wire         O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID;
	wire [7:0]   I_RX_DATA;
	wire [1:0]   O_AXI_BRESP, O_AXI_RRESP;
	int          bad_count = 0, n_tests = 0, cyc = 0;

	spt_trigger #(.SETUP_CYCLES(SETUP)) uut (.*);
	spt_host_model host (.i_clk(I_SYS_CLK), .o_valid(I_RX_VALID), .o_data(I_RX_DATA));

	initial forever #25 I_SYS_CLK = ~I_SYS_CLK;

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// a hang is cut short well past the few hundred cycles the tests need
	always @(posedge I_SYS_CLK) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		I_AXI_AWVALID <= 1'b1;
		I_AXI_AWADDR <= a;
		I_AXI_WVALID <= 1'b1;
		I_AXI_WDATA <= d;
		fork
			begin
				do @(posedge I_SYS_CLK); while (!O_AXI_AWREADY);
				I_AXI_AWVALID <= 1'b0;
			end
			begin
				do @(posedge I_SYS_CLK); while (!O_AXI_WREADY);
				I_AXI_WVALID <= 1'b0;
			end
		join
		// late bready makes the response stand for a cycle
		repeat (2) @(posedge I_SYS_CLK);
		I_AXI_BREADY <= 1'b1;
		do @(posedge I_SYS_CLK); while (!O_AXI_BVALID);
		chk(O_AXI_BRESP, e, "write response");
		I_AXI_BREADY <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		I_AXI_ARVALID <= 1'b1;
		I_AXI_ARADDR <= a;
		do @(posedge I_SYS_CLK); while (!O_AXI_ARREADY);
		I_AXI_ARVALID <= 1'b0;
		// late rready makes the read data stand for a cycle
		@(posedge I_SYS_CLK);
		I_AXI_RREADY <= 1'b1;
		do @(posedge I_SYS_CLK); while (!O_AXI_RVALID);
		chk(O_AXI_RDATA, e, "read data");
		chk(O_AXI_RRESP, er, "read response");
		I_AXI_RREADY <= 1'b0;
	endtask

	// lastat is the packet size; the final byte also closes a packet
	task automatic take(input int n, input logic [7:0] base, input int lastat);
		I_TX_READY <= 1'b1;
		for (int k = 0; k < n; k++) begin
			do @(posedge I_SYS_CLK); while (!(O_TX_VALID && I_TX_READY));
			chk(O_TX_DATA, base + k[7:0], "rf byte");
			chk(O_TX_LAST, ((k + 1) % lastat == 0) || (k == n - 1), "packet end");
		end
		// stall again so the next first byte stands until taken
		I_TX_READY <= 1'b0;
	endtask

	task automatic t_reset();
		rc(A_TH, `SPT_THRESH_RST, `SPT_RESP_OKAY);
		rc(A_TO, `SPT_TIMEOUT_RST, `SPT_RESP_OKAY);
		rc(A_MP, `SPT_MAXPKT_RST, `SPT_RESP_OKAY);
		rc(8'h10, 32'h0, `SPT_RESP_DECERR);
		chk(O_RX_READY, 1'b1, "buffer room");
	endtask

	task automatic t_regs();
		wc(A_MP, 32'h4, `SPT_RESP_OKAY);
		rc(A_TH, 32'h4, `SPT_RESP_OKAY);
		wc(A_TH, 32'h5, `SPT_RESP_SLVERR);
		rc(A_TH, 32'h4, `SPT_RESP_OKAY);
		wc(A_TH, 32'h0, `SPT_RESP_OKAY);
		rc(A_TH, 32'h0, `SPT_RESP_OKAY);
		wc(A_MP, 32'h0, `SPT_RESP_SLVERR);
		wc(A_MP, 32'h801, `SPT_RESP_SLVERR);
		wc(A_TO, 32'hFFFF, `SPT_RESP_OKAY);
		rc(A_TO, 32'hFFFF, `SPT_RESP_OKAY);
		// low byte only: the upper byte must keep its old value
		I_AXI_WSTRB <= 4'h1;
		wc(A_TO, 32'h12, `SPT_RESP_OKAY);
		I_AXI_WSTRB <= 4'hF;
		rc(A_TO, 32'hFF12, `SPT_RESP_OKAY);
		wc(A_TO, 32'h10000, `SPT_RESP_SLVERR);
		wc(A_ST, 32'h0, `SPT_RESP_SLVERR);
		wc(8'h10, 32'h0, `SPT_RESP_DECERR);
	endtask

	task automatic t_thresh();
		logic seen;
		seen = 1'b0;
		wc(A_TO, 32'h0, `SPT_RESP_OKAY);
		wc(A_TH, 32'h4, `SPT_RESP_OKAY);
		wc(A_CF, 32'h0002_0000, `SPT_RESP_OKAY);
		host.send(3, 0, 8'h40);
		repeat (200) begin
			@(posedge I_SYS_CLK);
			seen = seen | O_TX_VALID;
		end
		chk(seen, 1'b0, "early start");
		host.send(3, 0, 8'h43);
		repeat (4) @(posedge I_SYS_CLK);
		chk(O_TX_VALID, 1'b1, "threshold start");
		rc(A_ST, 32'h0001_0005, `SPT_RESP_OKAY);
		// hold the rf side off so the stalled byte must stand
		repeat (4) @(posedge I_SYS_CLK);
		take(6, 8'h40, 4);
	endtask

	task automatic t_timeout();
		int t;
		int exp;
		wc(A_MP, 32'h800, `SPT_RESP_OKAY);
		wc(A_TH, 32'h10, `SPT_RESP_OKAY);
		wc(A_TO, 32'h2, `SPT_RESP_OKAY);
		for (int c = 0; c < 3; c++) begin
			wc(A_CF, 32'h0002_0000 | (c == 0 ? 0 : c == 1 ? 1 : 3), `SPT_RESP_OKAY);
			// chars 6 cycles apart restart the silence count
			host.send(2, 5, 8'h60 + c[7:0]);
			exp = 2 * (10 + c) * 2 + SETUP - 5;
			t = 0;
			while (!O_TX_VALID && t < 1000) begin
				@(posedge I_SYS_CLK);
				t++;
			end
			chk(t >= exp - 2 && t <= exp + 3, 1'b1, "silence start");
			take(2, 8'h60 + c[7:0], 2);
		end
	endtask

	initial begin
		repeat (16) @(posedge I_SYS_CLK);
		I_SYS_RST <= 1'b0;
		@(posedge I_SYS_CLK);
		t_reset();
		t_regs();
		t_thresh();
		t_timeout();
		results();
	end
endmodule // serial_packetization_trigger_bench
bind spt_trigger spt_trigger_chk chk (.*);
`default_nettype wire

// ==== core/spt_char_timer.v ====
// character-time tick generator from bit divisor and framing
`timescale 1ns/1ns
`default_nettype none
module spt_char_timer #(
	parameter DIV_W = 16
) (
	input  wire             i_clk,
	input  wire             i_rst,
	input  wire             i_restart,
	input  wire [DIV_W-1:0] i_bit_div,
	input  wire [3:0]       i_char_bits,
	output wire             o_tick
);
	reg  [DIV_W-1:0] div_q;
	reg  [3:0]       bit_q;
	wire             bit_end;
	wire             char_end;

	// a zero divisor is treated as one cycle per bit
	assign bit_end  = (div_q + {{(DIV_W-1){1'b0}}, 1'b1} >= i_bit_div);
	assign char_end = bit_end && (bit_q + 4'h1 >= i_char_bits);
	assign o_tick   = char_end && !i_restart;

	always @(posedge i_clk) begin
		if (i_rst || i_restart) begin
			div_q <= {DIV_W{1'b0}};
			bit_q <= 4'h0;
		end else if (bit_end) begin
			div_q <= {DIV_W{1'b0}};
			bit_q <= char_end ? 4'h0 : bit_q + 4'h1;
		end else begin
			div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // spt_char_timer
`default_nettype wire

// ==== core/spt_delay.v ====
// one-shot delay counter, done pulses after the programmed cycles
`timescale 1ns/1ns
`default_nettype none
module spt_delay #(
	parameter CYCLES = 16000,
	parameter CNT_W  = 16
) (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_start,
	output wire o_busy,
	output wire o_done
);
	localparam [CNT_W-1:0] LAST = CYCLES - 1;
	reg             run_q;
	reg [CNT_W-1:0] cnt_q;

	assign o_busy = run_q;
	assign o_done = run_q && (cnt_q == LAST);

	always @(posedge i_clk) begin
		if (i_rst) begin
			run_q <= 1'b0;
			cnt_q <= {CNT_W{1'b0}};
		end else if (i_start && !run_q) begin
			run_q <= 1'b1;
			cnt_q <= {CNT_W{1'b0}};
		end else if (o_done) begin
			run_q <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
endmodule // spt_delay
`default_nettype wire

// ==== core/spt_trigger.v ====
// serial packetization trigger: buffer, start criteria, streaming, axi-lite registers
`timescale 1ns/1ns
`default_nettype none
`include "spt_defines.vh"
module spt_trigger #(
	parameter DEPTH        = 2048,
	parameter AW           = 11,
	parameter SETUP_CYCLES = `SPT_SETUP_CYC
) (
	input  wire        I_SYS_CLK,
	input  wire        I_SYS_RST,
	input  wire        I_RX_VALID,
	input  wire [7:0]  I_RX_DATA,
	output wire        O_RX_READY,
	output wire        O_TX_VALID,
	output wire [7:0]  O_TX_DATA,
	output wire        O_TX_LAST,
	input  wire        I_TX_READY,
	input  wire        I_AXI_AWVALID,
	output wire        O_AXI_AWREADY,
	input  wire [7:0]  I_AXI_AWADDR,
	input  wire        I_AXI_WVALID,
	output wire        O_AXI_WREADY,
	input  wire [31:0] I_AXI_WDATA,
	input  wire [3:0]  I_AXI_WSTRB,
	output wire        O_AXI_BVALID,
	input  wire        I_AXI_BREADY,
	output wire [1:0]  O_AXI_BRESP,
	input  wire        I_AXI_ARVALID,
	output wire        O_AXI_ARREADY,
	input  wire [7:0]  I_AXI_ARADDR,
	output wire        O_AXI_RVALID,
	input  wire        I_AXI_RREADY,
	output wire [31:0] O_AXI_RDATA,
	output wire [1:0]  O_AXI_RRESP
);
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_SETUP = 3'b010;
	localparam [2:0] ST_SEND  = 3'b100;
	// buffer depth is a power of two; the pointers wrap at 2**AW
	localparam [AW:0] FILL_MAX = {1'b1, {AW{1'b0}}};

	reg  [7:0]  mem [0:DEPTH-1];
	reg  [AW-1:0] wr_ptr_q;
	reg  [AW-1:0] rd_ptr_q;
	reg  [AW:0] fill_q;
	reg  [2:0]  state_q;
	reg  [11:0] thresh_q;
	reg  [15:0] timeout_q;
	reg  [11:0] maxpkt_q;
	reg         parity_select_q;
	reg         stop_bit_select_q;
	reg  [15:0] bit_div_q;
	reg  [11:0] rx_cnt_q;
	reg  [15:0] silence_q;
	reg  [11:0] pkt_cnt_q;
	reg         tx_valid_q;
	reg  [7:0]  tx_data_q;
	reg         tx_last_q;
	reg         aw_have_q;
	reg  [7:0]  aw_addr_q;
	reg         w_have_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         bvalid_q;
	reg  [1:0]  bresp_q;
	reg         rvalid_q;
	reg  [31:0] rdata_q;
	reg  [1:0]  rresp_q;
	reg  [31:0] wr_word;
	reg  [31:0] rd_word;
	reg  [1:0]  rd_resp;

	wire        push;
	wire        pop;
	wire        buf_empty;
	wire        char_tick;
	wire        thresh_hit;
	wire        silence_hit;
	wire        setup_done;
	wire        wr_fire;
	wire [3:0]  char_bits;
	wire [11:0] wr_val12;
	wire [15:0] wr_val16;

	// merge write data into a stored word by byte strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction

	// index decode: byte address over four
	function [7:0] reg_idx;
		input [7:0] addr;
		begin
			reg_idx = {2'b00, addr[7:2]};
		end
	endfunction

	assign buf_empty  = (fill_q == {(AW+1){1'b0}});
	assign O_RX_READY = (fill_q != FILL_MAX);
	assign push       = I_RX_VALID && O_RX_READY;
	assign pop        = (state_q == ST_SEND) && !buf_empty && (!tx_valid_q || I_TX_READY);

	// start, eight data, optional parity, one or two stop bits
	assign char_bits = `SPT_CHAR_BASE_BITS + {3'h0, parity_select_q} + {3'h0, stop_bit_select_q};

	// timer restarts per character and holds while nothing is buffered
	spt_char_timer #(
		.DIV_W (16)
	) u_char_timer (
		.i_clk       (I_SYS_CLK),
		.i_rst       (I_SYS_RST),
		.i_restart   (push || buf_empty || (state_q != ST_IDLE)),
		.i_bit_div   (bit_div_q),
		.i_char_bits (char_bits),
		.o_tick      (char_tick)
	);

	// threshold count reached with data waiting
	assign thresh_hit  = !buf_empty && (rx_cnt_q >= thresh_q);
	// silence trigger needs a received byte
	// zero timeout disables the silence path
	assign silence_hit = !buf_empty && (rx_cnt_q != 12'h000) && (timeout_q != 16'h0000)
		&& (silence_q >= timeout_q);

	// setup time between silence timeout and transmission
	spt_delay #(
		.CYCLES (SETUP_CYCLES),
		.CNT_W  (32)
	) u_setup (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_start ((state_q == ST_IDLE) && silence_hit && !thresh_hit),
		.o_busy  (),
		.o_done  (setup_done)
	);

	always @(posedge I_SYS_CLK) begin
		if (push) begin
			mem[wr_ptr_q] <= I_RX_DATA;
		end
	end

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			fill_q   <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				fill_q <= fill_q + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				fill_q <= fill_q - {{AW{1'b0}}, 1'b1};
			end
		end
	end

	// received count and silence count, kept only while idle and cleared once a packet starts
	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			rx_cnt_q  <= 12'h000;
			silence_q <= 16'h0000;
		end else if (state_q != ST_IDLE) begin
			rx_cnt_q  <= 12'h000;
			silence_q <= 16'h0000;
		end else begin
			if (push && rx_cnt_q != 12'hFFF) begin
				rx_cnt_q <= rx_cnt_q + 12'h001;
			end
			// any character restarts the silence count
			if (push) begin
				silence_q <= 16'h0000;
			end else if (char_tick && silence_q != 16'hFFFF) begin
				silence_q <= silence_q + 16'h0001;
			end
		end
	end

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (thresh_hit) begin
						state_q <= ST_SEND;
					end else if (silence_hit) begin
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (setup_done) begin
						state_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					// keep streaming until the buffer drains
					if (buf_empty && (!tx_valid_q || I_TX_READY)) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// output stage; last marks packet size limit or a drained buffer
	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			tx_valid_q <= 1'b0;
			tx_data_q  <= 8'h00;
			tx_last_q  <= 1'b0;
			pkt_cnt_q  <= 12'h000;
		end else if (pop) begin
			tx_valid_q <= 1'b1;
			tx_data_q  <= mem[rd_ptr_q];
			// close the packet at the maximum size
			if ((pkt_cnt_q + 12'h001 >= maxpkt_q)
				|| (fill_q == {{AW{1'b0}}, 1'b1} && !push)) begin
				tx_last_q <= 1'b1;
				pkt_cnt_q <= 12'h000;
			end else begin
				tx_last_q <= 1'b0;
				pkt_cnt_q <= pkt_cnt_q + 12'h001;
			end
		end else if (I_TX_READY) begin
			tx_valid_q <= 1'b0;
			tx_last_q  <= 1'b0;
		end
	end

	assign O_TX_VALID = tx_valid_q;
	assign O_TX_DATA  = tx_data_q;
	assign O_TX_LAST  = tx_last_q;

	// axi-lite write: address and data taken in either order
	assign O_AXI_AWREADY = !aw_have_q && !bvalid_q;
	assign O_AXI_WREADY  = !w_have_q && !bvalid_q;
	assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;

	always @* begin
		case (reg_idx(aw_addr_q))
			`SPT_IDX_THRESH:  wr_word = {20'h00000, thresh_q};
			`SPT_IDX_TIMEOUT: wr_word = {16'h0000, timeout_q};
			`SPT_IDX_MAXPKT:  wr_word = {20'h00000, maxpkt_q};
			`SPT_IDX_SERCFG:  wr_word = {bit_div_q, 14'h0000, stop_bit_select_q,
				parity_select_q};
			default:          wr_word = 32'h00000000;
		endcase
		wr_word = merge(wr_word, w_data_q, w_strb_q);
	end

	assign wr_val12 = wr_word[11:0];
	assign wr_val16 = wr_word[15:0];

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			aw_have_q         <= 1'b0;
			aw_addr_q         <= 8'h00;
			w_have_q          <= 1'b0;
			w_data_q          <= 32'h00000000;
			w_strb_q          <= 4'h0;
			bvalid_q          <= 1'b0;
			bresp_q           <= `SPT_RESP_OKAY;
			thresh_q          <= `SPT_THRESH_RST;
			timeout_q         <= `SPT_TIMEOUT_RST;
			maxpkt_q          <= `SPT_MAXPKT_RST;
			parity_select_q   <= 1'b0;
			stop_bit_select_q <= 1'b0;
			bit_div_q         <= `SPT_BITDIV_RST;
		end else begin
			if (I_AXI_AWVALID && O_AXI_AWREADY) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= I_AXI_AWADDR;
			end
			if (I_AXI_WVALID && O_AXI_WREADY) begin
				w_have_q <= 1'b1;
				w_data_q <= I_AXI_WDATA;
				w_strb_q <= I_AXI_WSTRB;
			end
			if (bvalid_q && I_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= `SPT_RESP_OKAY;
				case (reg_idx(aw_addr_q))
					`SPT_IDX_THRESH: begin
						// values above maximum packet size are refused
						if (wr_word[31:12] == 20'h00000 && wr_val12 <= maxpkt_q) begin
							thresh_q <= wr_val12;
						end else begin
							bresp_q <= `SPT_RESP_SLVERR;
						end
					end
					`SPT_IDX_TIMEOUT: begin
						if (wr_word[31:16] == 16'h0000) begin
							timeout_q <= wr_val16;
						end else begin
							bresp_q <= `SPT_RESP_SLVERR;
						end
					end
					`SPT_IDX_MAXPKT: begin
						if (wr_word[31:12] == 20'h00000 && wr_val12 != 12'h000
							&& wr_val12 <= `SPT_MAXPKT_LIMIT) begin
							maxpkt_q <= wr_val12;
							// pull threshold down with the new size
							if (wr_val12 < thresh_q) begin
								thresh_q <= wr_val12;
							end
						end else begin
							bresp_q <= `SPT_RESP_SLVERR;
						end
					end
					`SPT_IDX_SERCFG: begin
						parity_select_q   <= wr_word[`SPT_CFG_PARITY];
						stop_bit_select_q <= wr_word[`SPT_CFG_STOP];
						bit_div_q         <= wr_word[`SPT_CFG_DIV_LSB +: 16];
					end
					`SPT_IDX_STATUS: begin
						bresp_q <= `SPT_RESP_SLVERR;
					end
					default: begin
						bresp_q <= `SPT_RESP_DECERR;
					end
				endcase
			end
		end
	end

	assign O_AXI_BVALID = bvalid_q;
	assign O_AXI_BRESP  = bresp_q;

	// axi-lite read: one outstanding, data registered
	assign O_AXI_ARREADY = !rvalid_q;

	always @* begin
		rd_resp = `SPT_RESP_OKAY;
		case (reg_idx(I_AXI_ARADDR))
			`SPT_IDX_THRESH:  rd_word = {20'h00000, thresh_q};
			`SPT_IDX_TIMEOUT: rd_word = {16'h0000, timeout_q};
			`SPT_IDX_MAXPKT:  rd_word = {20'h00000, maxpkt_q};
			`SPT_IDX_SERCFG:  rd_word = {bit_div_q, 14'h0000, stop_bit_select_q,
				parity_select_q};
			`SPT_IDX_STATUS:  rd_word = {14'h0000, (state_q == ST_SETUP),
				(state_q == ST_SEND), {(15-AW){1'b0}}, fill_q};
			default: begin
				rd_word = 32'h00000000;
				rd_resp = `SPT_RESP_DECERR;
			end
		endcase
	end

	always @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `SPT_RESP_OKAY;
		end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_resp;
		end else if (I_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	assign O_AXI_RVALID = rvalid_q;
	assign O_AXI_RDATA  = rdata_q;
	assign O_AXI_RRESP  = rresp_q;
endmodule // spt_trigger
`default_nettype wire

// ==== shared/spt_defines.vh ====
// constants for the serial packetization trigger block
`ifndef SPT_DEFINES_VH
`define SPT_DEFINES_VH

// register indices; byte address is four times the index
`define SPT_IDX_THRESH     8'h20
`define SPT_IDX_TIMEOUT    8'h21
`define SPT_IDX_MAXPKT     8'h29
`define SPT_IDX_SERCFG     8'h30
`define SPT_IDX_STATUS     8'h31

// reset values and the maximum packet size limit
`define SPT_THRESH_RST     12'h800
`define SPT_TIMEOUT_RST    16'h0003
`define SPT_MAXPKT_RST     12'h800
`define SPT_MAXPKT_LIMIT   12'h800
`define SPT_BITDIV_RST     16'h00AE

// serial config register fields
`define SPT_CFG_PARITY     0
`define SPT_CFG_STOP       1
`define SPT_CFG_DIV_LSB    16

// status register fields
`define SPT_STAT_BUSY      16
`define SPT_STAT_SETUP     17

// character framing: start + 8 data + 1 stop
`define SPT_CHAR_BASE_BITS 4'hA

// axi responses
`define SPT_RESP_OKAY      2'h0
`define SPT_RESP_SLVERR    2'h2
`define SPT_RESP_DECERR    2'h3

// transmission setup time after a silence timeout
`define SPT_SETUP_US       800
`define SPT_CLK_MHZ        20
`define SPT_SETUP_CYC      (`SPT_SETUP_US * `SPT_CLK_MHZ)

`endif
